// *** hdl/sar_adc_consts.svh ***
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// register offsets on the plain port
`define OFS_CTRL0     3'h0
`define OFS_CTRL1     3'h1
`define OFS_RES_HI    3'h2
`define OFS_RES_LO    3'h3
`define OFS_FLAG      3'h4
`define OFS_IRQ_EN    3'h5

// field positions
`define GO_BIT        1
`define ON_BIT        0
`define CHS_LSB       2
`define JUSTIFY_BIT   7
`define CLKSEL_LSB    4
`define FLAG_BIT      6
`define IRQ_EN_BIT    6

// reset values
`define RST_BYTE      8'h00
`define RST_CHS       5'h00
`define RST_CLKSEL    3'h0
`define RST_PREF      2'h0

// channel codes of the last pin and the internal sources
`define CH_LAST_PIN   5'h07
`define CH_TEMP       5'h1D
`define CH_DAC        5'h1E
`define CH_FIXED_REF  5'h1F

// reference code for the external pin
`define PREF_EXT      2'h2

// rc oscillator selection: low two bits of the clock select
`define CLK_RC        2'h3

// timing: 10 bits, 23 half conversion-clock periods (11.5 periods)
`define RES_BITS      10
`define TOP_BIT       4'h9
`define SETTLE_HALVES 2'h2

`endif

// *** hdl/sar_adc_control.sv ***
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ns
`include "sar_adc_consts.svh"

// Overview of operation
// - ten-bit successive approximation into result pair
// - channel field picks one of eleven sources
// - reference field picks external pin or supply
// - clock field: six dividers or rc oscillator
// - one bit per period, 11.5 periods total
// - divided clock tracks the system clock
// - rc oscillator period independent of system clock
// - sleep conversions only on rc clock
// - completion always sets the complete flag
// - interrupt needs flag and enable together
// - enabled completion interrupt wakes from sleep
// - justify bit picks left or right alignment
// - enable first, then set go separately
// - completion clears go, flags, loads result
// - clearing go aborts, stores filled partial result
// - unused six bits of result read zero
module sar_adc_control
  import sar_adc_pkg::*;
(
  input  wire logic     sys_clk,      // system clock, 100 MHz
  input  wire logic     rst_n,        // synchronous reset, active low
  input  wire reg_req_t bus_req,      // register port request
  output logic [7:0]    reg_rdata,    // read data, cycle after strobe
  input  wire logic     rc_half_tick, // rc oscillator half-period pulse
  input  wire logic     cmp_high,     // held input at or above trial
  input  wire logic     sleep_mode,   // device is asleep
  output ana_ctl_t      ana_ctl,      // mux, sample, trial, reference
  output logic          irq_req,      // completion interrupt request
  output logic          wake_req      // wake request while asleep
);

  // half conversion-clock period in system cycles, minus one
  function automatic logic [4:0] half_limit(input logic [2:0] sel);
    logic [4:0] lim;
    lim = 5'h00;
    unique case (sel)
      3'b000: lim = 5'h00; // /2
      3'b100: lim = 5'h01; // /4
      3'b001: lim = 5'h03; // /8
      3'b101: lim = 5'h07; // /16
      3'b010: lim = 5'h0F; // /32
      3'b110: lim = 5'h1F; // /64
      default: lim = 5'h00; // x11 uses the rc ticks
    endcase
    return lim;
  endfunction : half_limit

  // partial result: undecided bits copy the last decided bit
  function automatic logic [9:0] fill_partial(
    input logic [9:0] sar,
    input logic [3:0] bit_idx,
    input logic       last,
    input logic       pending
  );
    logic [9:0] res;
    res = sar;
    for (int i = 0; i < `RES_BITS; i++) begin
      if (pending && (4'(i) <= bit_idx)) begin
        res[i] = last;
      end
    end
    return res;
  endfunction : fill_partial

  // one-hot source select, zero for reserved codes
  function automatic logic [10:0] chan_decode(input logic [4:0] channel_select);
    logic [10:0] oh;
    oh = 11'h000;
    if (channel_select <= `CH_LAST_PIN) begin
      oh[channel_select[2:0]] = 1'b1;
    end else if (channel_select == `CH_TEMP) begin
      oh[8] = 1'b1;
    end else if (channel_select == `CH_DAC) begin
      oh[9] = 1'b1;
    end else if (channel_select == `CH_FIXED_REF) begin
      oh[10] = 1'b1;
    end
    return oh; // reserved leaves the hold open
  endfunction : chan_decode

  // software-visible state
  logic [4:0]  chs_r;
  logic        on_r;
  logic        justify_r;
  logic [2:0]  clksel_r;
  logic [1:0]  pref_r;
  logic        flag_r;
  logic        irq_en_r;
  logic [7:0]  res_hi_r;
  logic [7:0]  res_lo_r;
  logic [7:0]  rdata_r;

  // sequencer state
  seq_state_t  state_r;
  seq_state_t  state_nxt;
  logic [4:0]  div_cnt_r;
  logic        phase_r;
  logic [1:0]  settle_r;
  logic [3:0]  bit_r;
  logic [9:0]  sar_r;
  logic        last_r;
  ana_ctl_t    ana_r;
  logic        irq_r;
  logic        wake_r;

  // decoded strobes
  wire         busy_w    = (state_r != ST_IDLE);
  wire         wr_ctrl0  = bus_req.wr && (bus_req.addr == `OFS_CTRL0);
  wire         wr_ctrl1  = bus_req.wr && (bus_req.addr == `OFS_CTRL1);
  wire         wr_flag   = bus_req.wr && (bus_req.addr == `OFS_FLAG);
  wire         wr_irq_en = bus_req.wr && (bus_req.addr == `OFS_IRQ_EN);
  wire         wd_go     = bus_req.wdata[`GO_BIT];
  wire         wd_on     = bus_req.wdata[`ON_BIT];
  wire         rc_sel    = (clksel_r[1:0] == `CLK_RC);

  // go only counts when the converter was already on and stays on
  wire         start_w   = wr_ctrl0 && wd_go && wd_on && on_r && !busy_w;

  // software clear of go while running stores the partial
  wire         abort_sw  = wr_ctrl0 && !wd_go && wd_on && busy_w;

  // turning off, or sleeping on a divided clock, drops the result
  wire         kill_off  = wr_ctrl0 && !wd_on && busy_w;
  wire         kill_slp  = sleep_mode && !rc_sel && busy_w;
  wire         kill_w    = kill_off || kill_slp;

  // half-period ticks from divider or rc oscillator
  wire         div_tick  = (div_cnt_r == half_limit(clksel_r));
  wire         half_tick = rc_sel ? rc_half_tick : div_tick;

  // one bit decision ends on the second half of its period
  wire         bit_done  = (state_r == ST_CONVERT) && half_tick && phase_r;
  wire         last_bit  = (bit_r == 4'h0);
  wire         settle_end = (state_r == ST_SETTLE) && half_tick
                            && (settle_r == `SETTLE_HALVES - 2'h1);
  wire         done_w    = settle_end && !kill_w && !abort_sw;

  // value stored on completion or software abort
  wire         pending_w = (state_r == ST_SAMPLE) || (state_r == ST_CONVERT);
  wire [9:0]   store_val = abort_sw ? fill_partial(sar_r, bit_r, last_r, pending_w)
                                    : sar_r;
  wire         store_w   = done_w || (abort_sw && !kill_w);

  // result alignment into the byte pair
  wire [7:0]   hi_val    = justify_r ? {6'h00, store_val[9:8]}
                                     : store_val[9:2];
  wire [7:0]   lo_val    = justify_r ? store_val[7:0]
                                     : {store_val[1:0], 6'h00};

  // read mux; unmapped offsets read zero
  wire [7:0]   ctrl0_rd  = {1'b0, chs_r, busy_w, on_r};
  wire [7:0]   ctrl1_rd  = {justify_r, clksel_r, 2'b00, pref_r};
  wire [7:0]   flag_rd   = {1'b0, flag_r, 6'h00};
  wire [7:0]   irq_en_rd = {1'b0, irq_en_r, 6'h00};
  wire [7:0]   rd_mux    =
    (bus_req.addr == `OFS_CTRL0)  ? ctrl0_rd  :
    (bus_req.addr == `OFS_CTRL1)  ? ctrl1_rd  :
    (bus_req.addr == `OFS_RES_HI) ? res_hi_r  :
    (bus_req.addr == `OFS_RES_LO) ? res_lo_r  :
    (bus_req.addr == `OFS_FLAG)   ? flag_rd   :
    (bus_req.addr == `OFS_IRQ_EN) ? irq_en_rd : `RST_BYTE;

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start_w) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (half_tick) begin
          state_nxt = ST_CONVERT; // hold after half a period
        end
      end
      ST_CONVERT: begin
        if (bit_done && last_bit) begin
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settle_end) begin
          state_nxt = ST_IDLE; // 23 halves = 11.5 periods
        end
      end
    endcase
    if (kill_w || abort_sw) begin
      state_nxt = ST_IDLE;
    end
  end

  // analog drive, registered so the macro sees clean levels
  wire         sample_w  = (state_nxt == ST_SAMPLE);
  wire [9:0]   trial_w   = (state_r == ST_CONVERT) ? (sar_r | (10'h001 << bit_r))
                                                   : sar_r;
  wire         ref_ext_w = (pref_r == `PREF_EXT); // reserved codes use supply

  // control register one
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      justify_r <= 1'b0;
      clksel_r  <= `RST_CLKSEL;
      pref_r    <= `RST_PREF;
    end else if (wr_ctrl1) begin
      justify_r <= bus_req.wdata[`JUSTIFY_BIT];
      clksel_r  <= bus_req.wdata[`CLKSEL_LSB +: 3];
      pref_r    <= bus_req.wdata[1:0];
    end
  end

  // control register zero; go lives in the sequencer state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      chs_r <= `RST_CHS;
      on_r  <= 1'b0;
    end else if (wr_ctrl0) begin
      chs_r <= bus_req.wdata[`CHS_LSB +: 5];
      on_r  <= wd_on;
    end
  end

  // complete flag: set beats a same-cycle software clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (done_w) begin
      flag_r <= 1'b1; // every completion, enable or not
    end else if (wr_flag) begin
      flag_r <= bus_req.wdata[`FLAG_BIT]; // cleared only here
    end
  end

  // interrupt enable
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_en_r <= 1'b0;
    end else if (wr_irq_en) begin
      irq_en_r <= bus_req.wdata[`IRQ_EN_BIT];
    end
  end

  // result pair, loaded on completion or software abort
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      res_hi_r <= `RST_BYTE;
      res_lo_r <= `RST_BYTE;
    end else if (store_w) begin
      res_hi_r <= hi_val;
      res_lo_r <= lo_val;
    end
  end

  // read data stands the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_r <= `RST_BYTE;
    end else begin
      rdata_r <= bus_req.rd ? rd_mux : `RST_BYTE;
    end
  end

  // sequencer state register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // divider restarts with each conversion so the first half is whole
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_cnt_r <= 5'h00;
    end else if (start_w || div_tick) begin
      div_cnt_r <= 5'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 5'h01;
    end
  end

  // half-period phase inside a bit and the settle tail
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_r  <= 1'b0;
      settle_r <= 2'h0;
    end else if (start_w) begin
      phase_r  <= 1'b0;
      settle_r <= 2'h0;
    end else if (half_tick) begin
      phase_r  <= (state_r == ST_CONVERT) ? ~phase_r : 1'b0;
      settle_r <= (state_r == ST_SETTLE) ? settle_r + 2'h1 : 2'h0;
    end
  end

  // approximation register, msb first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sar_r  <= 10'h000;
      bit_r  <= `TOP_BIT;
      last_r <= 1'b0;
    end else if (start_w) begin
      sar_r  <= 10'h000;
      bit_r  <= `TOP_BIT;
      last_r <= 1'b0;
    end else if (bit_done) begin
      sar_r[bit_r] <= cmp_high; // keep the bit if input is at or above trial
      last_r       <= cmp_high;
      bit_r        <= last_bit ? 4'h0 : bit_r - 4'h1;
    end
  end

  // analog side outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ana_r <= '0;
    end else begin
      ana_r.chan_onehot <= chan_decode(chs_r);
      ana_r.sample      <= sample_w;
      ana_r.trial       <= trial_w;
      ana_r.ref_ext     <= ref_ext_w;
    end
  end

  // interrupt and wake requests
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_r  <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r  <= flag_r && irq_en_r;
      wake_r <= flag_r && irq_en_r && sleep_mode;
    end
  end

  assign reg_rdata = rdata_r;
  assign ana_ctl   = ana_r;
  assign irq_req   = irq_r;
  assign wake_req  = wake_r;

endmodule : sar_adc_control

// *** hdl/sar_adc_pkg.sv ***
package sar_adc_pkg;

  // register access from software
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // drive toward the analog macro
  typedef struct packed {
    logic [10:0] chan_onehot;
    logic        sample;
    logic [9:0]  trial;
    logic        ref_ext;
  } ana_ctl_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT,
    ST_SETTLE
  } seq_state_t;

endpackage : sar_adc_pkg

// *** verification/analog_front_model.sv ***
`timescale 1ns/1ns
module analog_front_model
  import sar_adc_pkg::*;
#(
  parameter int RC_HALF = 7  // rc half period in system cycles
)(
  input  wire logic       sys_clk,      // system clock
  input  wire ana_ctl_t   ana_ctl,      // controls from the block
  input  wire logic [9:0] levels [11],  // source levels in codes
  output logic            rc_half_tick, // rc half-period pulse
  output logic            cmp_high      // held level at or above trial
);
  logic [9:0] held_r = 10'h155;
  int         cnt_r = 0;

  // rc oscillator runs free, unrelated to the system divider
  initial rc_half_tick = 1'b0;
  always @(posedge sys_clk) begin
    cnt_r <= (cnt_r == RC_HALF - 1) ? 0 : cnt_r + 1;
    rc_half_tick <= (cnt_r == RC_HALF - 1);
  end

  // an open mux drifts, so a stale level never passes for a sample
  always @(posedge sys_clk) begin
    if (ana_ctl.sample) begin
      held_r <= ~held_r;
      for (int i = 0; i < 11; i++)
        if (ana_ctl.chan_onehot[i]) held_r <= levels[i];
    end
  end
  assign cmp_high = (held_r >= ana_ctl.trial);
endmodule : analog_front_model

// *** verification/sar_adc_control_monitor.sv ***
`timescale 1ns/1ns
module sar_adc_control_monitor
  import sar_adc_pkg::*;
(
  input wire logic       sys_clk,      // system clock
  input wire logic       rst_n,        // synchronous reset
  input wire reg_req_t   bus_req,      // register request
  input wire logic [7:0] reg_rdata,    // read data
  input wire logic       rc_half_tick, // rc half-period pulse
  input wire logic       cmp_high,     // comparator level
  input wire logic       sleep_mode,   // device asleep
  input wire ana_ctl_t   ana_ctl,      // analog controls
  input wire logic       irq_req,      // interrupt request
  input wire logic       wake_req      // wake request
);
  logic        wr0;
  logic        wr1;
  logic [4:0]  channel_select;
  logic [10:0] chan_exp;
  logic [10:0] chan_exp_r;
  logic        ref_exp_r;

  // expected mux and reference, latched when software writes them
  assign wr0      = bus_req.wr && bus_req.addr == 3'h0;
  assign wr1      = bus_req.wr && bus_req.addr == 3'h1;
  assign channel_select      = bus_req.wdata[6:2];
  assign chan_exp = (channel_select < 5'h08) ? (11'h001 << channel_select) :
                    (channel_select >= 5'h1D) ? (11'h100 << (channel_select - 5'h1D)) : 11'h000;
  always_ff @(posedge sys_clk) begin
    if (wr0) chan_exp_r <= chan_exp;
    if (wr1) ref_exp_r <= (bus_req.wdata[1:0] == 2'h2);
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_mux_code: assert property (wr0 |-> ##2 ana_ctl.chan_onehot == chan_exp_r)
    else $error("channel mux does not follow code");
  a_mux_single: assert property ($onehot0(ana_ctl.chan_onehot))
    else $error("more than one source on the hold");
  a_ref_code: assert property (wr1 |-> ##2 ana_ctl.ref_ext == ref_exp_r)
    else $error("reference select does not follow code");
  a_wake_needs_irq: assert property (wake_req |-> irq_req)
    else $error("wake without interrupt request");
  a_wake_sleep_only: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake while awake");
  a_wake_when_due: assert property (irq_req && $past(sleep_mode) |-> wake_req)
    else $error("no wake for enabled completion");
  a_irq_holds: assert property (irq_req && !bus_req.wr && !$past(bus_req.wr) |=> irq_req)
    else $error("interrupt dropped without a write");
  a_rdata_idle: assert property (!bus_req.rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_msb_first: assert property ($fell(ana_ctl.sample) |-> ##[0:1] ana_ctl.trial == 10'h200)
    else $error("first trial is not the top bit");
endmodule : sar_adc_control_monitor

bind sar_adc_control sar_adc_control_monitor sar_adc_control_monitor_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .reg_rdata(reg_rdata),
  .rc_half_tick(rc_half_tick), .cmp_high(cmp_high), .sleep_mode(sleep_mode),
  .ana_ctl(ana_ctl), .irq_req(irq_req), .wake_req(wake_req));

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
module tb_top
  import sar_adc_pkg::*;
;
  logic        sys_clk, rst_n, sleep_mode, rc_half_tick, cmp_high, irq_req, wake_req;
  reg_req_t    bus_req;
  logic [7:0]  reg_rdata, d;
  ana_ctl_t    ana_ctl;
  logic [9:0]  levels [11];
  logic [15:0] last_res;
  int          n_fail, checks, i, k, t0;

  sar_adc_control sar_adc_control_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
    .reg_rdata(reg_rdata), .rc_half_tick(rc_half_tick), .cmp_high(cmp_high),
    .sleep_mode(sleep_mode), .ana_ctl(ana_ctl), .irq_req(irq_req), .wake_req(wake_req));
  analog_front_model analog_front_model_i (.sys_clk(sys_clk), .ana_ctl(ana_ctl),
    .levels(levels), .rc_half_tick(rc_half_tick), .cmp_high(cmp_high));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk) bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge sys_clk) bus_req <= '0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk) bus_req <= '0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // half conversion-clock in system cycles for the divided settings
  function automatic int halfc(input logic [2:0] s);
    return 1 << {s[1:0], s[2]};
  endfunction : halfc
  function automatic logic [4:0] pick();
    pick = 5'($urandom_range(10));
    if (pick > 5'h07) pick = pick + 5'h15;
  endfunction : pick
  // decided top bits match, the rest copy the last decided bit
  function automatic logic part_ok(input logic [9:0] r, input logic [9:0] v);
    logic [9:0] m;
    part_ok = 1'b0;
    for (int b = 0; b < 10; b++) begin
      m = 10'h3FF << b;
      if ((r & m) == (v & m) && (r & ~m) == (r[b] ? ~m : 10'h000)) part_ok = 1'b1;
    end
  endfunction : part_ok

  // stop: 0 complete, 1 clear go, 2 power off, 3 fall asleep
  task automatic conv(input logic [2:0] sel, input logic [4:0] c, input int stop);
    logic [9:0]  v, r;
    logic [15:0] res;
    logic        j, en, fl;
    logic [1:0]  p;
    int          h, dur;
    j = 1'($urandom);
    en = 1'($urandom);
    p = 2'($urandom);
    foreach (levels[q]) levels[q] = 10'($urandom);
    v = levels[(c > 5'h07) ? c - 5'h15 : c];
    h = (sel[1:0] == 2'h3) ? 7 : halfc(sel);
    fl = (stop == 0) || (stop == 3 && sel[1:0] == 2'h3);
    wr(3'h5, {1'b0, en, 6'h00});
    wr(3'h1, {j, sel, 2'b00, p});
    rd(3'h1);
    chk(d, {j, sel, 2'b00, p});
    wr(3'h0, {1'b0, c, 2'b01});     // on first, pin taken as analog
    repeat (20) @(posedge sys_clk); // acquisition delay, legal clock
    t0 = int'($time);
    wr(3'h0, {1'b0, c, 2'b11});
    if (stop > 0) begin
      repeat (9 * h) @(posedge sys_clk);
      if (stop == 3) sleep_mode <= 1'b1;
      else wr(3'h0, {1'b0, c, 1'b0, stop == 1});
    end
    k = 0;
    do begin rd(3'h0); k++; end while (d[1] && k < 500);
    chk(d[1], 0);
    dur = (int'($time) - t0) / 10;
    if (stop == 0 && h == halfc(sel)) chk(dur >= 23 * h && dur <= 23 * h + 8, 1);
    rd(3'h4);
    chk(d[6], fl);
    chk(irq_req, en & fl);
    chk(wake_req, en & fl & sleep_mode);
    rd(3'h2);
    res[15:8] = d;
    rd(3'h3);
    res[7:0] = d;
    r = j ? res[9:0] : res[15:6];
    if (!fl && stop != 1) chk(res, last_res);
    else chk(j ? res[15:10] : res[5:0], 0);
    if (stop == 1) chk(part_ok(r, v), 1);
    else if (fl && c != 5'h10) chk(r, v);
    last_res = res;
    sleep_mode <= 1'b0;
    wr(3'h4, 8'h00);
    rd(3'h4);
    chk(d[6], 0);
    chk(irq_req, 0);
  endtask : conv

  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    sleep_mode = 1'b0;
    n_fail = 0;
    checks = 0;
    last_res = 16'h0000;
    foreach (levels[q]) levels[q] = 10'h000;
    k = $urandom(15);
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    wr(3'h6, 8'hFF);
    for (i = 0; i < 8; i++) begin
      rd(3'(i));
      chk(d, 0);
    end
    wr(3'h0, 8'h03);
    rd(3'h0);
    chk(d[1], 0);
    wr(3'h0, 8'h00);
    for (i = 0; i < 8; i++) conv(3'(i), pick(), 0);
    for (i = 0; i < 8; i++) conv(3'($urandom), pick(), 1 + i % 3);
    conv(3'h0, 5'h10, 0);
    conv(3'h7, pick(), 3);
    summarize();
  end

  // cut a hang short well beyond the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    summarize();
  end
endmodule : tb_top
